// File: dac_parallel_load_readback_port_tb_top.sv
// self-checking bench for the parallel dac host controller
`timescale 1ns/1ps
`default_nettype none
`include "pdl_consts.svh"
module dac_parallel_load_readback_port_tb_top;
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	logic core_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic req_valid_in = 1'b0;
	logic req_read_in = 1'b0;
	logic [11:0] req_data_in = 12'h000;
	logic req_ready_out, done_out, sel_n_out, rd_wr_n_out, oe_n, sel_q;
	logic [11:0] rd_data_out, host_out, dev_out, dac_val, bus, d;
	logic [11:0] wr_last = 12'h000;
	logic exp_rd = 1'b1;
	int err_total = 0;
	int n_checks = 0;
	int seed = 73013;
	int lat, falls, low_cnt;
	assign bus = oe_n ? dev_out : host_out;
	always #2 core_clk_in = ~core_clk_in;
	pdl_host #(.DATA_W(12), .WAIT_EN(1)) dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.req_valid_in(req_valid_in), .req_read_in(req_read_in), .req_data_in(req_data_in),
		.req_ready_out(req_ready_out), .done_out(done_out), .rd_data_out(rd_data_out),
		.sel_n_out(sel_n_out), .rd_wr_n_out(rd_wr_n_out), .parallel_data_lines_in(bus),
		.parallel_data_lines_out(host_out), .parallel_data_lines_oe_n_out(oe_n));
	pdl_dev_model model (.rst_n_in(rst_n_in), .sel_n_in(sel_n_out), .rd_wr_n_in(rd_wr_n_out),
		.bus_in(bus), .bus_out(dev_out), .dac_out(dac_val));
	function automatic int exp_lat(input int wait_en);
		return `PDL_SETUP_CYC + `PDL_STROBE_CYC + `PDL_HOLD_CYC + (wait_en != 0 ? `PDL_WAIT_CYC : 0);
	endfunction
	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask
	task automatic wrap_up;
		if (err_total == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(negedge core_clk_in) begin
		sel_q <= sel_n_out;
		if (sel_q === 1'b1 && sel_n_out === 1'b0)
			falls++;
		if (sel_n_out === 1'b0)
			low_cnt++;
		if (oe_n === 1'b0 && rd_wr_n_out === 1'b1)
			chk("bus contention", 12'h000, 12'h001);
		if (sel_n_out === 1'b0) begin
			chk("direction", {11'h000, exp_rd}, {11'h000, rd_wr_n_out});
			chk("host drive", {11'h000, exp_rd}, {11'h000, oe_n});
		end
	end
	// valid held with other data while busy: must be ignored
	task automatic xfer(input logic rd, input logic [11:0] dw);
		@(negedge core_clk_in);
		chk("ready idle", 12'h001, {11'h000, req_ready_out});
		req_valid_in = 1'b1;
		req_read_in = rd;
		req_data_in = dw;
		exp_rd = rd;
		falls = 0;
		low_cnt = 0;
		@(negedge core_clk_in);
		req_data_in = ~dw;
		lat = 0;
		while (done_out !== 1'b1 && lat < 30) begin
			@(negedge core_clk_in);
			lat++;
			if (lat == 3)
				req_valid_in = 1'b0;
		end
		chk("latency", 12'(exp_lat(1)), 12'(lat));
		chk("ready busy", 12'h000, {11'h000, req_ready_out});
		chk("select pulses", 12'h001, 12'(falls));
		chk("select low cycles", 12'(`PDL_STROBE_CYC + `PDL_WAIT_CYC), 12'(low_cnt));
		if (rd)
			chk("readback", wr_last, rd_data_out);
		else begin
			wr_last = dw;
			chk("dac register", dw, dac_val);
		end
	endtask
	task automatic do_reset;
		rst_n_in = 1'b0;
		repeat (8) @(negedge core_clk_in);
		rst_n_in = 1'b1;
		wr_last = 12'h000;
		repeat (2) @(negedge core_clk_in);
	endtask
	initial begin
		do_reset();
		xfer(1'b1, 12'h000);
		xfer(1'b0, 12'hFFF);
		xfer(1'b0, 12'h000);
		xfer(1'b1, 12'h000);
		xfer(1'b0, 12'hA5A);
		xfer(1'b1, 12'h000);
		repeat (20) begin
			d = 12'($random(seed));
			xfer(1'b0, d);
			xfer(1'b1, 12'h000);
		end
		do_reset();
		xfer(1'b1, 12'h000);
		wrap_up();
	end
	initial begin
		#100000;
		err_total++;
		wrap_up();
	end
endmodule
`default_nettype wire

// File: pdl_consts.svh
// timing counts and widths for the parallel dac load and readback host
// ---------------------------------------------------------------------
// Contract
// - one whole data word per transfer, parallel
// - write while select and direction both low
// - host gives each write falling and rising edge
// - read while direction high and select low
// - each word framed by its own edge pair
// - host inserts one wait state if needed
// ---------------------------------------------------------------------
`ifndef PDL_CONSTS_SVH
`define PDL_CONSTS_SVH
`define PDL_DATA_W 12
`define PDL_CLK_PERIOD_NS 4
`define PDL_SETUP_NS 8
`define PDL_STROBE_NS 20
`define PDL_HOLD_NS 8
`define PDL_WAIT_NS 4
`define PDL_CYC(ns) ((((ns) + `PDL_CLK_PERIOD_NS - 1) / `PDL_CLK_PERIOD_NS) < 1 ? 1 : \
	(((ns) + `PDL_CLK_PERIOD_NS - 1) / `PDL_CLK_PERIOD_NS))
`define PDL_SETUP_CYC `PDL_CYC(`PDL_SETUP_NS)
`define PDL_STROBE_CYC `PDL_CYC(`PDL_STROBE_NS)
`define PDL_HOLD_CYC `PDL_CYC(`PDL_HOLD_NS)
`define PDL_WAIT_CYC `PDL_CYC(`PDL_WAIT_NS)
`endif

// File: pdl_dev_model.sv
// behavioural model of the parallel dac device port
`timescale 1ns/1ps
`default_nettype none
module pdl_dev_model (
	input wire logic rst_n_in,
	input wire logic sel_n_in,
	input wire logic rd_wr_n_in,
	input wire logic [11:0] bus_in,
	output logic [11:0] bus_out,
	output logic [11:0] dac_out
);
	logic [11:0] in_reg_r;
	logic [11:0] last_r = 12'h000;
	// edge triggered: only the select rise moves the word on
	always @(posedge sel_n_in or negedge rst_n_in) begin
		if (!rst_n_in)
			dac_out <= 12'h000;
		else if (!rd_wr_n_in)
			dac_out <= in_reg_r;
	end
	always @* begin
		if (!rst_n_in)
			in_reg_r = 12'h000;
		else if (!sel_n_in)
			in_reg_r = rd_wr_n_in ? dac_out : bus_in;
	end
	// released lines show the inverse so a stale sample cannot pass
	always @* begin
		if (!sel_n_in && rd_wr_n_in) begin
			bus_out = in_reg_r;
			last_r = in_reg_r;
		end else
			bus_out = ~last_r;
	end
endmodule
`default_nettype wire

// File: pdl_host.sv
// host controller that writes and reads back the parallel dac port
`timescale 1ns/1ps
`default_nettype none
`include "pdl_consts.svh"
module pdl_host #(
	parameter int DATA_W = `PDL_DATA_W,
	parameter int WAIT_EN = 1
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic req_valid_in,
	input wire logic req_read_in,
	input wire logic [DATA_W-1:0] req_data_in,
	output logic req_ready_out,
	output logic done_out,
	output logic [DATA_W-1:0] rd_data_out,
	output logic sel_n_out,
	output logic rd_wr_n_out,
	input wire logic [DATA_W-1:0] parallel_data_lines_in,
	output logic [DATA_W-1:0] parallel_data_lines_out,
	output logic parallel_data_lines_oe_n_out
);
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int SETUP_C = `PDL_SETUP_CYC;
	localparam int STROBE_C = `PDL_STROBE_CYC + (WAIT_EN != 0 ? `PDL_WAIT_CYC : 0);
	localparam int HOLD_C = `PDL_HOLD_CYC;
	pdl_pkg::pdl_state_t state_r;
	pdl_pkg::pdl_state_t state_nxt;
	logic [7:0] cnt_r;
	logic rd_r;
	logic [DATA_W-1:0] bus_sync;
	logic cnt_end;
	logic [7:0] low_len_r;
	logic [1:0] frame_falls_r;
	assign cnt_end = (cnt_r == 8'h00);
	// ---------------------------------------------------------------
	// pin sampling; the read path is off-domain so goes through two flops
	// ---------------------------------------------------------------
	pdl_sync #(.WIDTH(DATA_W)) u_sync (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.async_in(parallel_data_lines_in),
		.sync_out(bus_sync)
	);
	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			pdl_pkg::PDL_IDLE: begin
				if (req_valid_in && req_ready_out) begin
					state_nxt = pdl_pkg::PDL_SETUP;
				end
			end
			pdl_pkg::PDL_SETUP: begin
				if (cnt_end) begin
					state_nxt = pdl_pkg::PDL_STROBE;
				end
			end
			pdl_pkg::PDL_STROBE: begin
				if (cnt_end) begin
					state_nxt = pdl_pkg::PDL_HOLD;
				end
			end
			pdl_pkg::PDL_HOLD: begin
				if (cnt_end) begin
					state_nxt = pdl_pkg::PDL_DONE;
				end
			end
			pdl_pkg::PDL_DONE: begin
				state_nxt = pdl_pkg::PDL_IDLE;
			end
			default: begin
				state_nxt = pdl_pkg::PDL_IDLE;
			end
		endcase
	end
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			state_r <= pdl_pkg::PDL_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			cnt_r <= 8'h00;
		end else if (state_r != state_nxt) begin
			case (state_nxt)
				pdl_pkg::PDL_SETUP: cnt_r <= 8'(SETUP_C - 1);
				pdl_pkg::PDL_STROBE: cnt_r <= 8'(STROBE_C - 1);
				pdl_pkg::PDL_HOLD: cnt_r <= 8'(HOLD_C - 1);
				default: cnt_r <= 8'h00;
			endcase
		end else if (!cnt_end) begin
			cnt_r <= cnt_r - 8'h01;
		end
	end
	// ---------------------------------------------------------------
	// request capture
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			rd_r <= 1'b0;
			parallel_data_lines_out <= '0;
		end else if (state_r == pdl_pkg::PDL_IDLE && req_valid_in && req_ready_out) begin
			rd_r <= req_read_in;
			parallel_data_lines_out <= req_data_in;
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			req_ready_out <= 1'b0;
		end else begin
			req_ready_out <= (state_nxt == pdl_pkg::PDL_IDLE);
		end
	end
	// ---------------------------------------------------------------
	// pins: select low only in strobe, so every word gets both edges
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			sel_n_out <= 1'b1;
		end else begin
			sel_n_out <= (state_nxt != pdl_pkg::PDL_STROBE);
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			rd_wr_n_out <= 1'b1;
		end else if (state_nxt == pdl_pkg::PDL_IDLE || state_nxt == pdl_pkg::PDL_DONE) begin
			rd_wr_n_out <= 1'b1;
		end else if (state_r == pdl_pkg::PDL_IDLE) begin
			rd_wr_n_out <= req_read_in;
		end
	end
	// released on reads and while idle, so the device never meets our drive
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			parallel_data_lines_oe_n_out <= 1'b1;
		end else if (state_nxt == pdl_pkg::PDL_IDLE || state_nxt == pdl_pkg::PDL_DONE) begin
			parallel_data_lines_oe_n_out <= 1'b1;
		end else if (state_r == pdl_pkg::PDL_IDLE) begin
			parallel_data_lines_oe_n_out <= req_read_in;
		end
	end
	// ---------------------------------------------------------------
	// readback; sampled late in strobe, sync adds two cycles so take at hold end
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			rd_data_out <= '0;
			done_out <= 1'b0;
		end else begin
			done_out <= (state_r == pdl_pkg::PDL_HOLD) && cnt_end;
			if (state_r == pdl_pkg::PDL_HOLD && cnt_end && rd_r) begin
				rd_data_out <= bus_sync;
			end
		end
	end
	// ---------------------------------------------------------------
	// check helpers
	// ---------------------------------------------------------------
	// select-low run length; frames are short, so 8 bits never wrap
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			low_len_r <= 8'h00;
		end else if (!sel_n_out) begin
			low_len_r <= low_len_r + 8'h01;
		end else begin
			low_len_r <= 8'h00;
		end
	end
	// falls of select since the request was taken, saturating
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			frame_falls_r <= 2'h0;
		end else if (state_r == pdl_pkg::PDL_IDLE) begin
			frame_falls_r <= 2'h0;
		end else if (!sel_n_out && low_len_r == 8'h00 && frame_falls_r != 2'h3) begin
			frame_falls_r <= frame_falls_r + 2'h1;
		end
	end
	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_no_drive_read: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		rd_wr_n_out |-> parallel_data_lines_oe_n_out) else $error("host drove bus during read");
	a_sel_edges: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		$fell(sel_n_out) |-> !sel_n_out[*2]) else $error("select pulse too short");
	a_write_dir: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(!sel_n_out && !rd_r) |-> (!rd_wr_n_out && !parallel_data_lines_oe_n_out)) else $error("write not low");
	a_read_dir: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(!sel_n_out && rd_r) |-> rd_wr_n_out) else $error("read direction wrong");
	a_done_after: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		$rose(sel_n_out) |-> ##[1:8] done_out) else $error("no done after strobe");
	a_data_stable: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		!sel_n_out |-> $stable(parallel_data_lines_out)) else $error("write data moved");
	a_sel_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		req_ready_out |-> sel_n_out) else $error("select low while idle");
	a_strobe_len: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		$rose(sel_n_out) |-> (low_len_r == 8'(STROBE_C))) else $error("strobe length wrong");
	a_dir_before: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		$fell(sel_n_out) |-> ($stable(rd_wr_n_out) && $stable(parallel_data_lines_oe_n_out)))
		else $error("direction set too late");
	a_dir_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		$rose(sel_n_out) |-> $stable(rd_wr_n_out) ##1 $stable(rd_wr_n_out)) else $error("direction not held");
	a_write_drive: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		!rd_wr_n_out |-> !parallel_data_lines_oe_n_out) else $error("write without drive");
	a_oe_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		req_ready_out |-> (parallel_data_lines_oe_n_out && rd_wr_n_out)) else $error("bus not released idle");
	a_ready_after: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		done_out |=> req_ready_out) else $error("not ready after done");
	a_done_pulse: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		done_out |=> !done_out) else $error("done longer than one cycle");
	a_frame_once: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		done_out |-> (frame_falls_r == 2'h1)) else $error("not one select frame per word");
endmodule
`default_nettype wire

// File: pdl_pkg.sv
// types for the parallel dac load and readback host
package pdl_pkg;
	typedef enum logic [4:0] {
		PDL_IDLE = 5'h01,
		PDL_SETUP = 5'h02,
		PDL_STROBE = 5'h04,
		PDL_HOLD = 5'h08,
		PDL_DONE = 5'h10
	} pdl_state_t;
endpackage

// File: pdl_sync.sv
// two flop synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module pdl_sync #(
	parameter int WIDTH = 12
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			always_ff @(posedge core_clk_in) begin
				if (!rst_n_in) begin
					meta_r[gi] <= 1'b0;
					sync_out[gi] <= 1'b0;
				end else begin
					meta_r[gi] <= async_in[gi];
					sync_out[gi] <= meta_r[gi];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire
